/* File: rtl/mon_link.sv */
// Monitor-mode serial link engine: entry divider, security check, command
// decoder, memory access and APB register window.
// Assumes a synchronous memory port with one cycle read latency and a CPU
// core that performs the actual stacking and unstacking on request.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mon_link
	import mon_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic        POR_B,
	input  wire logic        ENTRY_HV,
	input  wire logic        DIV_SEL,
	input  wire logic        SER_IN,
	output logic             SER_OUT,
	output logic             SER_OE_B,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic      [15:0] MEM_ADDR,
	output logic             MEM_RD,
	output logic             MEM_WR,
	output logic      [7:0]  MEM_WDATA,
	input  wire logic [7:0]  MEM_RDATA,
	input  wire logic [15:0] CPU_SP,
	input  wire logic        MASS_ERASE,
	input  wire logic        FETCH_VALID,
	input  wire logic [15:0] FETCH_ADDR,
	output logic             ILL_ADDR_RST,
	output logic             STACK_ENTRY,
	output logic             RUN_GO,
	output logic      [15:0] RUN_PC
);
	ser_if lk ();

	st_t         st_r;
	st_t         after_r;
	cmd_t        cmd_r;
	cmd_t        rx_cmd;
	rd_use_t     rd_use_r;
	logic        strap_done_r;
	logic        div_hi_r;
	logic        bypass_r;
	logic        erased_r;
	logic        sec_done_r;
	logic        sec_bad_r;
	logic [3:0]  sec_idx_r;
	logic [1:0]  need_r;
	logic [15:0] addr_r;
	logic [15:0] idx_r;
	logic [7:0]  data_r;
	logic [7:0]  hold_r;
	logic [7:0]  out_byte_r;
	logic        tx_sent_r;
	logic        rd_vld_r;
	logic [15:0] mem_addr_r;
	logic        mem_rd_r;
	logic        mem_wr_r;
	logic [7:0]  mem_wdata_r;
	logic        run_go_r;
	logic [15:0] run_pc_r;
	logic        stack_r;
	logic        ill_r;
	logic [7:0]  opc_r [NCMD];
	logic [31:0] prdata_r;
	logic [NCMD-1:0] opc_hit;

	ser_phy u_phy (
		.clk       (CLK),
		.rst_b     (RST_B),
		.lk        (lk.phy),
		.line_in   (SER_IN),
		.line_out  (SER_OUT),
		.line_oe_b (SER_OE_B)
	);

	// Shared decode terms
	wire [15:0] sp1      = CPU_SP + SP_RET_OFS; // RULE11
	wire [7:0]  sp_hi    = sp1[15:8];
	wire        in_flash = (mem_addr_r >= FLASH_BASE);
	wire [7:0]  rd_filt  = (!bypass_r && in_flash) ? INVALID_BYTE : MEM_RDATA; // RULE16
	wire [7:0]  sec_ref  = erased_r ? ERASED_BYTE : MEM_RDATA; // RULE19
	wire        sec_last = (sec_idx_r == SEC_LEN - 4'h1);
	wire        rx_known = (rx_cmd != CMD_NONE);
	wire [1:0]  rx_ops   = rx_known ? CMD_OPS[rx_cmd] : 2'h0;
	wire        sec_pass = (st_r == ST_SECW) && !sec_bad_r;

	// Opcode match per command slot
	genvar k;
	generate
		for (k = 0; k < NCMD; k++)
		begin : g_opc
			assign opc_hit[k] = (lk.rx_data == opc_r[k]); // RULE23
		end
	endgenerate

	// First matching slot names the command
	always_comb
	begin
		rx_cmd = CMD_NONE;
		for (int i = NCMD - 1; i >= 0; i--)
			if (opc_hit[i])
				rx_cmd = cmd_t'(i[2:0]); // RULE9
	end

	// What the line driver is asked to send in each sending state
	wire send_st = (st_r == ST_GAP) || (st_r == ST_ECHO) || (st_r == ST_WAIT) ||
		(st_r == ST_BRKH) || (st_r == ST_BRKT);
	assign lk.bit_cyc  = div_hi_r ? DIV_HI : DIV_LO;
	assign lk.tx_req   = send_st && !tx_sent_r;
	assign lk.tx_abort = (st_r == ST_WAIT) && lk.rx_brk; // RULE5
	assign lk.tx_drive = (st_r != ST_WAIT);
	assign lk.tx_pat   = (st_r == ST_ECHO) ? {2'b11, out_byte_r, 1'b0} : // RULE22
		(st_r == ST_BRKT) ? 11'h400 : 11'h7FF;
	assign lk.tx_len   = (st_r == ST_GAP)  ? GAP_BITS : // RULE6
		(st_r == ST_WAIT) ? WAIT_BITS :
		(st_r == ST_BRKH) ? BRK_HI_BITS :
		(st_r == ST_BRKT) ? BRK_BITS : FRAME_BITS;

	// One request per sending state
	always_ff @(posedge CLK or negedge RST_B)
		if (!RST_B)
			tx_sent_r <= 1'b0;
		else if (lk.tx_done || lk.tx_abort)
			tx_sent_r <= 1'b0;
		else if (lk.tx_req)
			tx_sent_r <= 1'b1;

	// Bypass and erase memory only forget on power-on reset
	always_ff @(posedge CLK or negedge POR_B)
		if (!POR_B)
		begin
			bypass_r <= 1'b0;
			erased_r <= 1'b0;
		end
		else
		begin
			bypass_r <= bypass_r || sec_pass; // RULE15
			erased_r <= erased_r || MASS_ERASE; // RULE19
		end

	// Fetch guard for a locked part
	always_ff @(posedge CLK or negedge RST_B)
		if (!RST_B)
			ill_r <= 1'b0;
		else
			ill_r <= FETCH_VALID && !bypass_r && (FETCH_ADDR >= FLASH_BASE); // RULE16

	// Main sequencer; memory strobes are one-cycle pulses
	always_ff @(posedge CLK or negedge RST_B)
		if (!RST_B)
		begin
			st_r         <= ST_STRAP;
			after_r      <= ST_RXB;
			cmd_r        <= CMD_NONE;
			rd_use_r     <= USE_HOST;
			strap_done_r <= 1'b0;
			div_hi_r     <= 1'b1;
			sec_done_r   <= 1'b0;
			sec_bad_r    <= 1'b0;
			sec_idx_r    <= 4'h0;
			need_r       <= 2'h0;
			addr_r       <= 16'h0000;
			idx_r        <= 16'h0000;
			data_r       <= 8'h00;
			hold_r       <= 8'h00;
			out_byte_r   <= 8'h00;
			rd_vld_r     <= 1'b0;
			mem_addr_r   <= 16'h0000;
			mem_rd_r     <= 1'b0;
			mem_wr_r     <= 1'b0;
			mem_wdata_r  <= 8'h00;
			run_go_r     <= 1'b0;
			run_pc_r     <= 16'h0000;
			stack_r      <= 1'b0;
		end
		else
		begin
			mem_rd_r <= 1'b0;
			mem_wr_r <= 1'b0;
			run_go_r <= 1'b0;
			stack_r  <= 1'b0;
			rd_vld_r <= mem_rd_r;
			unique case (st_r)
				// Straps are caught once, just after release
				ST_STRAP:
				begin
					strap_done_r <= 1'b1;
					div_hi_r     <= !ENTRY_HV || DIV_SEL; // RULE1 RULE2 RULE3
					stack_r      <= 1'b1; // RULE12
					sec_done_r   <= bypass_r; // RULE15
					st_r         <= bypass_r ? ST_BRKT : ST_RXB;
				end
				// No break goes out before the security bytes are all in, unless bypass is already set
				ST_RXB:
					if (lk.rx_brk && sec_done_r) // RULE17
						st_r <= ST_BRKH; // RULE20
					else if (lk.rx_valid && !sec_done_r)
					begin
						hold_r     <= lk.rx_data;
						mem_rd_r   <= 1'b1;
						mem_addr_r <= SEC_BASE + {12'h000, sec_idx_r}; // RULE14
						rd_use_r   <= USE_SEC;
						st_r       <= ST_MRD;
					end
					else if (lk.rx_valid)
					begin
						out_byte_r <= lk.rx_data; // RULE4
						st_r       <= ST_GAP;
						if (need_r == 2'h0)
						begin
							cmd_r   <= rx_cmd;
							need_r  <= rx_ops;
							after_r <= (rx_known && rx_ops == 2'h0) ? ST_WAIT : ST_RXB;
						end
						else
						begin
							need_r  <= need_r - 2'h1;
							after_r <= (need_r == 2'h1) ? ST_WAIT : ST_RXB;
							if (cmd_r == CMD_INDEXED_WRITE_CMD || (cmd_r == CMD_WRITE && need_r == 2'h1))
								data_r <= lk.rx_data;
							else
								addr_r <= {addr_r[7:0], lk.rx_data};
						end
					end
				ST_MRD:
					if (rd_vld_r)
						unique case (rd_use_r)
							USE_SEC:
							begin
								sec_bad_r  <= sec_bad_r || (sec_ref != hold_r); // RULE14
								out_byte_r <= hold_r; // RULE4
								sec_idx_r  <= sec_idx_r + 4'h1;
								after_r    <= sec_last ? ST_SECW : ST_RXB;
								st_r       <= ST_GAP;
							end
							USE_HOST:
							begin
								out_byte_r <= rd_filt; // RULE16
								after_r    <= ST_RXB;
								st_r       <= ST_GAP; // RULE6
							end
							USE_PCH:
							begin
								run_pc_r[15:8] <= MEM_RDATA;
								mem_rd_r       <= 1'b1;
								mem_addr_r     <= CPU_SP + PC_LO_OFS; // RULE13
								rd_use_r       <= USE_PCL;
							end
							USE_PCL:
							begin
								run_pc_r[7:0] <= MEM_RDATA;
								run_go_r      <= 1'b1; // RULE12
								st_r          <= ST_RXB;
							end
						endcase
				// Two driven idle bits, then the byte itself
				ST_GAP:
					if (lk.tx_done)
						st_r <= ST_ECHO;
				ST_ECHO:
					if (lk.tx_done)
						st_r <= after_r;
				// Silent window where the host may still cancel
				ST_WAIT:
					if (lk.rx_brk)
						st_r <= ST_BRKH; // RULE5
					else if (lk.tx_done)
						st_r <= ST_EXEC;
				// Command acts only after its final echo and wait
				ST_EXEC:
				begin
					rd_use_r <= USE_HOST;
					unique case (cmd_r)
						CMD_READ, CMD_INDEXED_READ_CMD:
						begin
							mem_rd_r   <= 1'b1; // RULE7
							mem_addr_r <= (cmd_r == CMD_READ) ? addr_r : idx_r;
							idx_r      <= ((cmd_r == CMD_READ) ? addr_r : idx_r) + 16'h1; // RULE10
							st_r       <= ST_MRD;
						end
						CMD_WRITE, CMD_INDEXED_WRITE_CMD:
						begin
							mem_wr_r    <= 1'b1;
							mem_wdata_r <= data_r;
							mem_addr_r  <= (cmd_r == CMD_WRITE) ? addr_r : idx_r;
							idx_r       <= ((cmd_r == CMD_WRITE) ? addr_r : idx_r) + 16'h1; // RULE10
							st_r        <= ST_RXB;
						end
						CMD_STACK_POINTER_READ_CMD:
						begin
							out_byte_r <= sp_hi; // RULE11
							after_r    <= ST_SPLO;
							st_r       <= ST_GAP;
						end
						CMD_RUN:
						begin
							mem_rd_r   <= 1'b1;
							mem_addr_r <= CPU_SP + PC_HI_OFS; // RULE13
							rd_use_r   <= USE_PCH;
							st_r       <= ST_MRD;
						end
						default:
							st_r <= ST_RXB;
					endcase
				end
				ST_SPLO:
				begin
					out_byte_r <= sp1[7:0];
					after_r    <= ST_RXB;
					st_r       <= ST_GAP;
				end
				// Verdict byte is written whole; other bits of it read zero
				ST_SECW:
				begin
					mem_wr_r    <= 1'b1;
					mem_addr_r  <= SEC_STAT_ADDR;
					mem_wdata_r <= sec_bad_r ? 8'h00 : (8'h01 << SEC_STAT_BIT); // RULE18
					sec_done_r  <= 1'b1;
					st_r        <= ST_BRKT; // RULE17
				end
				ST_BRKH:
				begin
					need_r <= 2'h0;
					if (lk.tx_done)
						st_r <= ST_BRKT; // RULE20
				end
				ST_BRKT:
					if (lk.tx_done)
						st_r <= ST_RXB;
			endcase
		end

	// APB window: zero wait states, read data captured in the setup cycle
	wire        apb_setup = PSEL && !PENABLE;
	wire        apb_acc   = PSEL && PENABLE;
	wire        hit_a     = (PADDR == OPC_A_OFS);
	wire        hit_b     = (PADDR == OPC_B_OFS);
	wire        hit_s     = (PADDR == STAT_OFS);
	wire        map_ok    = hit_a || hit_b || hit_s;
	wire [31:0] word_a    = {opc_r[3], opc_r[2], opc_r[1], opc_r[0]};
	wire [31:0] word_b    = {16'h0000, opc_r[5], opc_r[4]};
	wire [31:0] word_s    = {idx_r, 8'h00, st_r, div_hi_r, sec_bad_r, sec_done_r, bypass_r};
	wire [31:0] rd_mux    = hit_a ? word_a : hit_b ? word_b : hit_s ? word_s : 32'h0000_0000;

	// Opcode slots, four to a word
	generate
		for (k = 0; k < NCMD; k++)
		begin : g_opr
			wire slot_hit = (k < 4) ? hit_a : hit_b;
			always_ff @(posedge CLK or negedge RST_B)
				if (!RST_B)
					opc_r[k] <= OPC_RST[k];
				else if (apb_acc && PWRITE && slot_hit)
					opc_r[k] <= PWDATA[(k % 4) * OPC_W +: OPC_W]; // RULE23
		end
	endgenerate

	always_ff @(posedge CLK or negedge RST_B)
		if (!RST_B)
			prdata_r <= 32'h0000_0000;
		else if (apb_setup && !PWRITE)
			prdata_r <= rd_mux;

	assign PRDATA       = prdata_r;
	assign PREADY       = 1'b1;
	assign PSLVERR      = apb_acc && !map_ok;
	assign MEM_ADDR     = mem_addr_r;
	assign MEM_RD       = mem_rd_r;
	assign MEM_WR       = mem_wr_r;
	assign MEM_WDATA    = mem_wdata_r;
	assign ILL_ADDR_RST = ill_r;
	assign STACK_ENTRY  = stack_r;
	assign RUN_GO       = run_go_r;
	assign RUN_PC       = run_pc_r;

	// Checks on the sequencer
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	property p_div_hv;
		$rose(strap_done_r) && $past(ENTRY_HV) |-> div_hi_r == $past(DIV_SEL);
	endproperty
	a_div_hv: assert property (p_div_hv) else $error("divider not from select pin"); // RULE1 RULE2

	property p_div_lv;
		$rose(strap_done_r) && !$past(ENTRY_HV) |-> div_hi_r && lk.bit_cyc == DIV_HI;
	endproperty
	a_div_lv: assert property (p_div_lv) else $error("normal entry not divide 1024"); // RULE3

	property p_gap;
		(st_r == ST_GAP && lk.tx_req) |-> lk.tx_len == GAP_BITS && lk.tx_drive && &lk.tx_pat;
	endproperty
	a_gap: assert property (p_gap) else $error("idle gap wrong"); // RULE6

	property p_echo;
		(st_r == ST_GAP && lk.tx_done) |=> st_r == ST_ECHO && lk.tx_req &&
			lk.tx_pat[8:1] == out_byte_r && !lk.tx_pat[0];
	endproperty
	a_echo: assert property (p_echo) else $error("echo does not follow gap"); // RULE4

	property p_wait;
		(st_r == ST_ECHO && lk.tx_done && after_r == ST_WAIT) |=>
			st_r == ST_WAIT && lk.tx_len == WAIT_BITS && !lk.tx_drive;
	endproperty
	a_wait: assert property (p_wait) else $error("command wait missing"); // RULE5

	property p_cancel;
		(st_r == ST_WAIT && lk.rx_brk) |=> st_r == ST_BRKH ##1 need_r == 2'h0;
	endproperty
	a_cancel: assert property (p_cancel) else $error("break did not cancel"); // RULE5 RULE20

	property p_sp;
		(st_r == ST_EXEC && cmd_r == CMD_STACK_POINTER_READ_CMD) |=> out_byte_r == $past(sp_hi) ##0 st_r == ST_GAP;
	endproperty
	a_sp: assert property (p_sp) else $error("stack read not pointer plus one"); // RULE11

	property p_idx;
		(st_r == ST_EXEC && cmd_r == CMD_INDEXED_READ_CMD) |=> idx_r == $past(idx_r) + 16'h1 ##0 MEM_RD;
	endproperty
	a_idx: assert property (p_idx) else $error("index did not advance"); // RULE10

	property p_rdy;
		(st_r == ST_BRKT && lk.tx_req) |-> sec_done_r && lk.tx_len == BRK_BITS &&
			lk.tx_pat[9:0] == 10'h000;
	endproperty
	a_rdy: assert property (p_rdy) else $error("break sent before security"); // RULE17

	property p_ill;
		FETCH_VALID && !bypass_r && FETCH_ADDR >= FLASH_BASE |=> ILL_ADDR_RST;
	endproperty
	a_ill: assert property (p_ill) else $error("locked fetch not trapped"); // RULE16

	property p_byp;
		@(posedge CLK) disable iff (!POR_B) bypass_r |=> bypass_r;
	endproperty
	a_byp: assert property (p_byp) else $error("bypass lost without power-on"); // RULE15
endmodule : mon_link
`default_nettype wire

/* File: rtl/mon_pkg.sv */
// Constants and types for the monitor serial link engine and its line driver.
// Assumes one clock that also serves as the baud reference clock.
// Functional notes
// (RULE1) High-voltage entry, select high: divide 1024
// (RULE2) High-voltage entry, select low: divide 512
// (RULE3) Normal-supply blank-vector entry always divides 1024
// (RULE4) Every received byte is echoed back
// (RULE5) Wait 11 bits after command; break cancels
// (RULE6) Two idle bits before echo and data
// (RULE7) Read data follows echo of last byte
// (RULE8) Host waits one bit after each echo
// (RULE9) Six commands: read, write, indexed, stack, run
// (RULE10) Indexed commands step through consecutive addresses
// (RULE11) Stack pointer read returns pointer plus one
// (RULE12) Entry stacks registers; run restores them
// (RULE13) Stacked program counter at pointer plus five/six
// (RULE14) Eight received bytes compared with stored code
// (RULE15) Bypass survives all but power-on reset
// (RULE16) Mismatch: invalid flash reads, fetch resets
// (RULE17) Break sent only after eight security bytes; with bypass set, the code sends it at once after a warm reset
// (RULE18) Match sets bit six of status byte
// (RULE19) Mass erase leaves security code all ones
// (RULE20) Break: ten lows; answer two highs, echo
// (RULE21) NRZ signalling, same rate both directions
// (RULE22) Start low, eight bits LSB first, stop high
// (RULE23) Command opcodes are configurable values
package mon_pkg;
	localparam int                BITCNT_W      = 11;
	localparam logic [10:0]       DIV_HI        = 11'h400;
	localparam logic [10:0]       DIV_LO        = 11'h200;
	localparam logic [3:0]        GAP_BITS      = 4'h2;
	localparam logic [3:0]        WAIT_BITS     = 4'hB;
	localparam logic [3:0]        BRK_HI_BITS   = 4'h2;
	localparam logic [3:0]        BRK_BITS      = 4'hA;
	localparam logic [3:0]        FRAME_BITS    = 4'hA;
	localparam logic [3:0]        SEC_LEN       = 4'h8;
	localparam logic [15:0]       SEC_BASE      = 16'hFFF6;
	localparam logic [15:0]       SEC_STAT_ADDR = 16'h0060;
	localparam int                SEC_STAT_BIT  = 6;
	localparam logic [7:0]        ERASED_BYTE   = 8'hFF;
	localparam logic [15:0]       SP_RET_OFS    = 16'h0001;
	localparam logic [15:0]       PC_HI_OFS     = 16'h0005;
	localparam logic [15:0]       PC_LO_OFS     = 16'h0006;
	localparam logic [15:0]       FLASH_BASE    = 16'h8000;
	localparam logic [7:0]        INVALID_BYTE  = 8'hAD;
	localparam logic [7:0]        OPC_A_OFS     = 8'h00;
	localparam logic [7:0]        OPC_B_OFS     = 8'h04;
	localparam logic [7:0]        STAT_OFS      = 8'h08;
	localparam int                OPC_W         = 8;
	localparam int                NCMD          = 6;
	localparam int                STAT_ST_LSB   = 4;
	localparam int                STAT_IDX_LSB  = 16;
	localparam logic [7:0]        OPC_RST [NCMD] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
	localparam logic [1:0]        CMD_OPS [NCMD] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h0, 2'h0};
	typedef enum logic [2:0] {CMD_READ, CMD_WRITE, CMD_INDEXED_READ_CMD, CMD_INDEXED_WRITE_CMD,
		CMD_STACK_POINTER_READ_CMD, CMD_RUN, CMD_NONE = 3'h7} cmd_t;
	typedef enum logic [1:0] {USE_HOST, USE_SEC, USE_PCH, USE_PCL} rd_use_t;
	typedef enum logic [3:0] {
		ST_STRAP = 4'h0, ST_RXB = 4'h1, ST_GAP = 4'h3, ST_ECHO = 4'h2,
		ST_WAIT = 4'h6, ST_EXEC = 4'h7, ST_MRD = 4'h5, ST_SPLO = 4'h4,
		ST_SECW = 4'hC, ST_BRKH = 4'hD, ST_BRKT = 4'hF} st_t;
endpackage : mon_pkg

/* File: rtl/ser_if.sv */
// Link between the monitor engine and its serial line driver.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface ser_if;
	logic [10:0] bit_cyc;
	logic        tx_req;
	logic [10:0] tx_pat;
	logic [3:0]  tx_len;
	logic        tx_drive;
	logic        tx_abort;
	logic        tx_busy;
	logic        tx_done;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        rx_brk;
	modport eng (output bit_cyc, tx_req, tx_pat, tx_len, tx_drive, tx_abort,
		input tx_busy, tx_done, rx_valid, rx_data, rx_brk);
	modport phy (input bit_cyc, tx_req, tx_pat, tx_len, tx_drive, tx_abort,
		output tx_busy, tx_done, rx_valid, rx_data, rx_brk);
endinterface : ser_if
`default_nettype wire

/* File: rtl/ser_phy.sv */
// Half-duplex single-wire serial line driver and receiver.
// Assumes line input already synchronous; one pattern shifter serves bytes,
// breaks, driven idle and silent waits.
`timescale 1ns/1ps
`default_nettype none
module ser_phy
	import mon_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	ser_if.phy        lk,
	input  wire logic line_in,
	output logic      line_out,
	output logic      line_oe_b
);
	logic                tx_act_r;
	logic                tx_drv_r;
	logic [10:0]         tx_sh_r;
	logic [3:0]          tx_left_r;
	logic [BITCNT_W-1:0] tx_cnt_r;
	logic                tx_done_r;
	logic                rx_act_r;
	logic                rx_arm_r;
	logic                rx_v_r;
	logic                rx_b_r;
	logic [3:0]          rx_bit_r;
	logic [BITCNT_W-1:0] rx_cnt_r;
	logic [9:0]          rx_sh_r;

	// Same bit period both ways; receiver deaf while we drive the wire
	wire tx_bit_end = (tx_cnt_r == lk.bit_cyc - 11'h1); // RULE21
	wire rx_listen  = !(tx_act_r && tx_drv_r);
	wire rx_last    = (rx_bit_r == FRAME_BITS - 4'h1);

	// Pattern shifter, LSB first, refills with idle-high
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			tx_act_r  <= 1'b0;
			tx_drv_r  <= 1'b0;
			tx_sh_r   <= 11'h7FF;
			tx_left_r <= 4'h0;
			tx_cnt_r  <= '0;
			tx_done_r <= 1'b0;
		end
		else
		begin
			tx_done_r <= 1'b0;
			if (lk.tx_abort)
				tx_act_r <= 1'b0;
			else if (!tx_act_r && lk.tx_req)
			begin
				tx_act_r  <= 1'b1;
				tx_drv_r  <= lk.tx_drive;
				tx_sh_r   <= lk.tx_pat;
				tx_left_r <= lk.tx_len;
				tx_cnt_r  <= '0;
			end
			else if (tx_act_r && tx_bit_end)
			begin
				tx_cnt_r  <= '0;
				tx_sh_r   <= {1'b1, tx_sh_r[10:1]}; // RULE22
				tx_left_r <= tx_left_r - 4'h1;
				tx_act_r  <= (tx_left_r != 4'h1);
				tx_done_r <= (tx_left_r == 4'h1);
			end
			else if (tx_act_r)
				tx_cnt_r <= tx_cnt_r + 11'h1;
		end

	// Mid-bit sampling; re-arm only after the line returns high
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			rx_act_r <= 1'b0;
			rx_arm_r <= 1'b0;
			rx_v_r   <= 1'b0;
			rx_b_r   <= 1'b0;
			rx_bit_r <= 4'h0;
			rx_cnt_r <= '0;
			rx_sh_r  <= 10'h000;
		end
		else
		begin
			rx_v_r <= 1'b0;
			rx_b_r <= 1'b0;
			if (!rx_listen)
			begin
				rx_act_r <= 1'b0;
				rx_arm_r <= 1'b0;
			end
			else if (!rx_act_r)
			begin
				if (!rx_arm_r)
					rx_arm_r <= line_in;
				else if (!line_in)
				begin
					rx_act_r <= 1'b1;
					rx_cnt_r <= lk.bit_cyc >> 1;
					rx_bit_r <= 4'h0;
				end
			end
			else if (rx_cnt_r == '0)
			begin
				rx_sh_r  <= {line_in, rx_sh_r[9:1]}; // RULE22
				rx_cnt_r <= lk.bit_cyc - 11'h1;
				rx_bit_r <= rx_bit_r + 4'h1;
				if (rx_last)
				begin
					rx_act_r <= 1'b0;
					rx_arm_r <= 1'b0;
					rx_v_r   <= line_in;
					rx_b_r   <= !line_in && (rx_sh_r[9:1] == 9'h000); // RULE20
				end
			end
			else
				rx_cnt_r <= rx_cnt_r - 11'h1;
		end

	// Status back to the engine and pin drive
	assign lk.tx_busy  = tx_act_r;
	assign lk.tx_done  = tx_done_r;
	assign lk.rx_valid = rx_v_r;
	assign lk.rx_brk   = rx_b_r;
	assign lk.rx_data  = rx_sh_r[8:1];
	assign line_out    = tx_act_r ? tx_sh_r[0] : 1'b1;
	assign line_oe_b   = !(tx_act_r && tx_drv_r);
endmodule : ser_phy
`default_nettype wire

/* File: tb/host_model.sv */
// Host end of the single-wire monitor link: byte sender and frame receiver.
// Assumes the bench resolves the pulled-up wire; the host only pulls low.
`timescale 1ns/1ps
`default_nettype none
module host_model
#(
	parameter int T = 512
)
(
	input  wire logic clk,
	input  wire logic line,
	output logic      drv_b
);
	// Released wire floats high, so idle needs no drive
	initial drv_b = 1'b1;

	// One frame; the leading idle bit keeps clear of the last echo
	task automatic send(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		repeat (T) @(posedge clk);
		for (int i = 0; i < 10; i++)
		begin
			drv_b <= fr[i];
			repeat (T) @(posedge clk);
		end
	endtask : send

	// Mid-bit sampling; a break shows as ten low samples
	task automatic recv(output logic [9:0] fr, output int w);
		w = 0;
		while (line !== 1'b0 && w < 40 * T)
		begin
			@(posedge clk);
			w++;
		end
		repeat (T / 2) @(posedge clk);
		for (int i = 0; i < 10; i++)
		begin
			fr[i] = line;
			repeat (T) @(posedge clk);
		end
	endtask : recv
endmodule : host_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench: APB window, security entry, stack read and run.
// Assumes the host model on a pulled-up wire and a hashed memory image.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import mon_pkg::*;
;
	localparam int T = 512;
	logic        CLK, RST_B, POR_B, ENTRY_HV, DIV_SEL, PSEL, PENABLE, PWRITE;
	logic        SER_OUT, SER_OE_B, PREADY, PSLVERR, MEM_RD, MEM_WR, MASS_ERASE;
	logic        FETCH_VALID, ILL_ADDR_RST, STACK_ENTRY, RUN_GO, drv_b, got_run, sl;
	logic [7:0]  PADDR, MEM_WDATA, MEM_RDATA, wd, r;
	logic [15:0] MEM_ADDR, CPU_SP, FETCH_ADDR, RUN_PC, wa, pc, sp1;
	logic [31:0] PWDATA, PRDATA, rd;
	wire logic   SER_IN;
	int          err_count, total_checks, seed, n_entry, n;

	assign SER_IN = (SER_OE_B | SER_OUT) & drv_b; // Pull-up plus two low drivers
	mon_link i_dut (.*);
	host_model #(.T(T)) i_host (.clk(CLK), .line(SER_IN), .drv_b(drv_b));

	function automatic logic [7:0] f(input logic [15:0] a);
		return a[15:8] ^ a[7:0] ^ 8'h5A;
	endfunction : f

	initial
	begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	// Memory with one cycle of read latency; watchers of writes and pulses
	always @(posedge CLK)
	begin
		if (MEM_RD)
			MEM_RDATA <= f(MEM_ADDR);
		if (MEM_WR)
			{wa, wd} <= {MEM_ADDR, MEM_WDATA};
		if (STACK_ENTRY)
			n_entry <= n_entry + 1;
		if (RUN_GO)
			{got_run, pc} <= {1'b1, RUN_PC};
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	task automatic bail;
		err_count++;
		wrap_up();
	endtask : bail

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Zero-wait slave, yet the access phase still waits for ready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		PSEL    <= 1'b1;
		PWRITE  <= wr;
		PADDR   <= a;
		PWDATA  <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		for (k = 0; PREADY !== 1'b1 && k < 50; k++)
			@(posedge CLK);
		rd = PRDATA;
		sl = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
		if (k == 50)
			bail();
	endtask : apb

	// Frame plus the idle time before its start bit
	task automatic rx(input logic [9:0] e, input int lo, input int hi);
		logic [9:0] fr;
		int         w;
		i_host.recv(fr, w);
		if (w >= 40 * T)
			bail();
		chk({22'h0, fr}, {22'h0, e});
		chk({31'h0, w >= lo && w < hi}, 32'h1);
	endtask : rx

	// Flash fetch traps only while locked; looked at mid-cycle
	task automatic fetch(input logic e);
		FETCH_ADDR  <= FLASH_BASE | 16'($random(seed));
		FETCH_VALID <= 1'b1;
		@(posedge CLK);
		FETCH_VALID <= 1'b0;
		@(negedge CLK);
		chk({31'h0, ILL_ADDR_RST}, {31'h0, e});
		@(posedge CLK);
	endtask : fetch

	initial
	begin
		seed = 85277;
		{err_count, total_checks, n_entry, got_run} = '0;
		{RST_B, POR_B, PSEL, PENABLE, PWRITE, MASS_ERASE, FETCH_VALID, DIV_SEL} = '0;
		{PADDR, PWDATA, FETCH_ADDR, MEM_RDATA} = '0;
		ENTRY_HV = 1'b1;
		CPU_SP = 16'($random(seed));
		r = 8'($random(seed));
		sp1 = CPU_SP + 16'h1;
		repeat (4) @(posedge CLK);
		RST_B <= 1'b1;
		POR_B <= 1'b1;
		@(posedge CLK);
		apb(1'b1, OPC_A_OFS, {r + 8'h3, r + 8'h2, r + 8'h1, r});
		apb(1'b0, OPC_A_OFS, 32'h0);
		chk(rd, {r + 8'h3, r + 8'h2, r + 8'h1, r});
		apb(1'b1, OPC_B_OFS, {16'h0, r + 8'h5, r + 8'h4});
		apb(1'b0, OPC_B_OFS, 32'h0);
		chk(rd, {16'h0, r + 8'h5, r + 8'h4});
		apb(1'b0, 8'h0C, 32'h0);
		chk(rd ^ {sl, 31'h0}, 32'h8000_0000);
		fetch(1'b1);
		$display("test opcode window done");
		for (int i = 0; i < 8; i++)
		begin
			i_host.send(f(SEC_BASE + 16'(i)));
			rx({1'b1, f(SEC_BASE + 16'(i)), 1'b0}, T, 2 * T);
		end
		rx(10'h000, 0, 40 * T);
		chk({8'h0, wa, wd}, {8'h0, SEC_STAT_ADDR, 8'h40});
		apb(1'b0, STAT_OFS, 32'h0);
		chk({28'h0, rd[3:0]}, 32'h3);
		chk(n_entry, 1);
		fetch(1'b0);
		$display("test security entry done");
		i_host.send(r + 8'h4);
		rx({1'b1, r + 8'h4, 1'b0}, T, 2 * T);
		rx({1'b1, sp1[15:8], 1'b0}, 11 * T, 14 * T);
		rx({1'b1, sp1[7:0], 1'b0}, T, 2 * T);
		$display("test stack read done");
		i_host.send(r + 8'h5);
		rx({1'b1, r + 8'h5, 1'b0}, T, 2 * T);
		for (n = 0; got_run !== 1'b1 && n < 16 * T; n++)
			@(posedge CLK);
		if (n == 16 * T)
			bail();
		chk({16'h0, pc}, {16'h0, f(CPU_SP + 16'h5), f(CPU_SP + 16'h6)});
		chk({31'h0, n >= 10 * T}, 32'h1);
		$display("test run done");
		// Warm resets keep the bypass; straps are taken afresh each time
		for (int i = 0; i < 2; i++)
		begin
			{ENTRY_HV, DIV_SEL} <= {~i[0], ~i[0]};
			RST_B <= 1'b0;
			@(posedge CLK);
			RST_B <= 1'b1;
			rx(10'h000, 0, 4 * T);
			apb(1'b0, STAT_OFS, 32'h0);
			chk({28'h0, rd[3:0]}, 32'hB);
		end
		chk(n_entry, 3);
		$display("test warm reset done");
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
